/* logic/dsa_map.svh */
// Offsets, field positions, reset values and counts for the dual-slope sequencer
`ifndef DSA_MAP_SVH
`define DSA_MAP_SVH
// ----------------------------------------------------------------
// Timing and counter chain
// ----------------------------------------------------------------
`define DSA_CLK_PERIOD_NS 50
`define DSA_DECADES 5
`define DSA_STATE_SPAN 10000
`define DSA_DIGIT_MAX 4'h9
`define DSA_DIGIT_PRE 4'h8
`define DSA_DIGIT_ZERO 4'h0
`define DSA_DIGIT_ONE 4'h1
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DSA_ADDR_W 5
`define DSA_OFS_CTRL 5'h00
`define DSA_OFS_STATUS 5'h04
`define DSA_OFS_MASK 5'h08
`define DSA_OFS_INFO 5'h0C
`define DSA_OFS_COUNT 5'h10
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define DSA_CTRL_HOLD 0
`define DSA_EV_W 2
`define DSA_EV_DONE 0
`define DSA_EV_OVLD 1
`define DSA_INFO_STATE_LO 0
`define DSA_INFO_POL 2
`define DSA_INFO_OVLD 3
`define DSA_INFO_BLANK 4
`define DSA_INFO_HELD 5
`define DSA_RST_CTRL 1'h0
`define DSA_RST_EV 2'h0
`define DSA_CODE_AZ 2'h0
`define DSA_CODE_SIG 2'h1
`define DSA_CODE_REF1 2'h2
`define DSA_CODE_REF2 2'h3
`endif

/* logic/dsa_pkg.sv */
// Types shared by the dual-slope sequencer and its bench
package dsa_pkg;
  // ----------------------------------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_AZ = 4'b0001,
    ST_SIG = 4'b0010,
    ST_REF1 = 4'b0100,
    ST_REF2 = 4'b1000
  } dsa_state_t;
  // ----------------------------------------------------------------
  // Analog switch controls, high closes a switch
  // ----------------------------------------------------------------
  typedef struct packed {
    logic input_ground_switch;
    logic ref_charge_switch;
    logic feedback_switch;
    logic signal_input_switch;
    logic positive_ref_switch;
    logic negative_ref_switch;
  } dsa_switch_t;
  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dsa_bus_t;
endpackage

/* logic/dsa_sequencer.sv */
// Dual-slope converter sequencer: decade chain, switch drive, latch and registers
//
// Function
// - Auto-zero closes ground, charge, feedback switches
// - Signal integrate closes only signal switch
// - Every state lasts 10,000 clock counts
// - Comparator captured into polarity at integrate end
// - Positive polarity picks negative reference, else positive
// - Reference phase spans two states
// - Comparator registered once per clock
// - States change at start of count 9999
// - State advances one count before fourth decade carry
// - Clock drives all five decades always; here a hold (low clear bus or software hold) keeps the lower four at zero
// - Entering state 10 clears only fifth decade
// - Zero crossing issues latch pulse copying count
// - Latch pulse lasts one clock period
// - Overload blanks display during auto-zero
// - Low clear bus holds auto-zero, lower decades
// - Data-valid pulse at end of measurement
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "dsa_map.svh"

module dsa_sequencer import dsa_pkg::*; #(
  parameter int DECADES = `DSA_DECADES
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clear_bus_n_in,
  input wire logic comparator_in,
  input wire dsa_bus_t bus_in,
  output logic [31:0] rdata_out,
  output dsa_switch_t switch_out,
  output logic [1:0] state_out,
  output logic polarity_out,
  output logic latch_pulse_out,
  output logic [4*DECADES-1:0] count_out,
  output logic blank_out,
  output logic data_valid_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int CW = 4 * DECADES;

  dsa_state_t state_r;
  dsa_state_t state_nxt;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic [DECADES-1:0] nine_w;
  logic [DECADES-1:0] ena_w;
  logic cmp_r;
  logic polarity_r;
  logic polarity_nxt;
  logic done_r;
  logic done_nxt;
  logic ovld_r;
  logic ovld_nxt;
  logic ctrl_hold_r;
  logic [`DSA_EV_W-1:0] status_r;
  logic [`DSA_EV_W-1:0] status_nxt;
  logic [`DSA_EV_W-1:0] mask_r;
  logic [`DSA_EV_W-1:0] mask_nxt;
  logic [`DSA_EV_W-1:0] event_w;
  logic [31:0] rd_data_w;
  dsa_switch_t switch_nxt;

  // ----------------------------------------------------------------
  // State code helper
  // ----------------------------------------------------------------
  function automatic logic [1:0] state_code(input dsa_state_t st);
    logic [1:0] code;
    code = `DSA_CODE_AZ;
    unique case (st)
      ST_AZ: code = `DSA_CODE_AZ;
      ST_SIG: code = `DSA_CODE_SIG;
      ST_REF1: code = `DSA_CODE_REF1;
      ST_REF2: code = `DSA_CODE_REF2;
      default: code = `DSA_CODE_AZ;
    endcase
    return code;
  endfunction

  // ----------------------------------------------------------------
  // Hold and timing decode
  // ----------------------------------------------------------------
  // Clear bus low or software hold parks the converter
  wire hold_w = !clear_bus_n_in || ctrl_hold_r;
  wire ref_phase_w = (state_r == ST_REF1) || (state_r == ST_REF2);
  // Upper three low decades at nine, ones digit at eight
  wire upper_nine_w = &nine_w[DECADES-2:1];
  wire pre_carry_w = upper_nine_w && (count_r[3:0] == `DSA_DIGIT_PRE);
  // Lower decades at 9999: the fourth decade carry
  wire carry_w = ena_w[DECADES-1];
  // Look-ahead of the carry so the state lands with count 9999
  wire adv_w = !hold_w && pre_carry_w;
  // First cycle of state 10 sits on the 9999 count
  wire top_clr_w = (state_r == ST_REF1) && carry_w;

  // ----------------------------------------------------------------
  // Decade counter chain
  // ----------------------------------------------------------------
  // Synchronous carry: a decade steps when all below read nine
  assign ena_w[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < DECADES; g++) begin : gen_dec
      wire [3:0] dig_w = count_r[4*g +: 4];
      assign nine_w[g] = (dig_w == `DSA_DIGIT_MAX);
      if (g > 0) begin : gen_ena
        assign ena_w[g] = ena_w[g-1] && nine_w[g-1];
      end
      if (g < DECADES - 1) begin : gen_low
        // Lower decades share the clear bus
        assign count_nxt[4*g +: 4] = hold_w ? `DSA_DIGIT_ZERO :
                                     !ena_w[g] ? dig_w :
                                     nine_w[g] ? `DSA_DIGIT_ZERO :
                                     dig_w + `DSA_DIGIT_ONE;
      end else begin : gen_top
        // Top decade ignores the clear bus; cleared entering state 10
        assign count_nxt[4*g +: 4] = top_clr_w ? `DSA_DIGIT_ZERO :
                                     !ena_w[g] ? dig_w :
                                     nine_w[g] ? `DSA_DIGIT_ZERO :
                                     dig_w + `DSA_DIGIT_ONE;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // State sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (hold_w) begin
      state_nxt = ST_AZ;
    end else if (adv_w) begin
      // Each state spans one full 10,000 count of the low decades
      unique case (state_r)
        ST_AZ: state_nxt = ST_SIG;
        ST_SIG: state_nxt = ST_REF1;
        ST_REF1: state_nxt = ST_REF2;
        ST_REF2: state_nxt = ST_AZ;
        default: state_nxt = ST_AZ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Measurement events
  // ----------------------------------------------------------------
  // Comparator left the captured sign: integrator crossed zero
  wire cross_w = ref_phase_w && !done_r && (cmp_r != polarity_r);
  // Reference phase ran out with no crossing
  wire ovl_ev_w = (state_r == ST_REF2) && adv_w && !done_r && !cross_w;
  wire latch_w = cross_w || ovl_ev_w;
  // End of the measurement cycle, state 11 wrapping to 00
  wire valid_w = (state_r == ST_REF2) && adv_w;
  // Overload latch shows the count just reached, 19999
  wire [CW-1:0] latch_val_w = cross_w ? count_r : count_nxt;

  assign event_w[`DSA_EV_DONE] = valid_w;
  assign event_w[`DSA_EV_OVLD] = ovl_ev_w;

  // Polarity taken at the end of signal integrate only
  assign polarity_nxt = (state_r == ST_SIG && adv_w) ? cmp_r : polarity_r;
  // Done clears when a new signal integrate begins
  assign done_nxt = (state_r == ST_AZ && adv_w) ? 1'b0 :
                    cross_w ? 1'b1 : done_r;
  // Overload stands until a valid crossing is latched
  assign ovld_nxt = ovl_ev_w ? 1'b1 : cross_w ? 1'b0 : ovld_r;

  // ----------------------------------------------------------------
  // Switch decoder
  // ----------------------------------------------------------------
  always_comb begin
    switch_nxt = '0;
    unique case (state_nxt)
      ST_AZ: begin
        switch_nxt.input_ground_switch = 1'b1;
        switch_nxt.ref_charge_switch = 1'b1;
        switch_nxt.feedback_switch = 1'b1;
      end
      ST_SIG: begin
        switch_nxt.signal_input_switch = 1'b1;
      end
      ST_REF1, ST_REF2: begin
        // Drive the reference that walks the ramp back to zero
        switch_nxt.negative_ref_switch = polarity_nxt;
        switch_nxt.positive_ref_switch = !polarity_nxt;
      end
      default: switch_nxt = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  wire sel_ctrl_w = (bus_in.addr == `DSA_OFS_CTRL);
  wire sel_status_w = (bus_in.addr == `DSA_OFS_STATUS);
  wire sel_mask_w = (bus_in.addr == `DSA_OFS_MASK);
  wire sel_info_w = (bus_in.addr == `DSA_OFS_INFO);
  wire sel_count_w = (bus_in.addr == `DSA_OFS_COUNT);
  wire wr_ctrl_w = bus_in.wr && sel_ctrl_w;
  wire wr_status_w = bus_in.wr && sel_status_w;
  wire wr_mask_w = bus_in.wr && sel_mask_w;
  wire [`DSA_EV_W-1:0] w1c_w = wr_status_w ? bus_in.wdata[`DSA_EV_W-1:0] : '0;

  // A new event beats a same-cycle clear
  assign status_nxt = (status_r & ~w1c_w) | event_w;
  assign mask_nxt = wr_mask_w ? bus_in.wdata[`DSA_EV_W-1:0] : mask_r;

  // Live view of the sequencer for software
  wire [31:0] info_w = {26'h0, hold_w, blank_out, ovld_r, polarity_r,
                        state_code(state_r)};
  // Unmapped offsets read as zero
  assign rd_data_w = sel_ctrl_w ? {31'h0, ctrl_hold_r} :
                     sel_status_w ? {30'h0, status_r} :
                     sel_mask_w ? {30'h0, mask_r} :
                     sel_info_w ? info_w :
                     sel_count_w ? {{(32-CW){1'b0}}, count_out} :
                     32'h0;

  // ----------------------------------------------------------------
  // Sequencer and counter registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_AZ;
      count_r <= '0;
      polarity_r <= 1'b0;
      done_r <= 1'b0;
      ovld_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      polarity_r <= polarity_nxt;
      done_r <= done_nxt;
      ovld_r <= ovld_nxt;
    end
  end

  // Comparator sampled once per edge; glitches between edges are missed
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_r <= 1'b0;
    end else begin
      cmp_r <= comparator_in;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Outputs follow the next state so they change with it
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      switch_out <= '0;
      state_out <= `DSA_CODE_AZ;
      polarity_out <= 1'b0;
      blank_out <= 1'b0;
    end else begin
      switch_out <= switch_nxt;
      state_out <= state_code(state_nxt);
      polarity_out <= polarity_nxt;
      blank_out <= ovld_nxt && (state_nxt == ST_AZ);
    end
  end

  // Count copied and latch pulse released within one period
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= '0;
      latch_pulse_out <= 1'b0;
      data_valid_out <= 1'b0;
    end else begin
      latch_pulse_out <= latch_w;
      data_valid_out <= valid_w;
      if (latch_w) begin
        count_out <= latch_val_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_hold_r <= `DSA_RST_CTRL;
      status_r <= `DSA_RST_EV;
      mask_r <= `DSA_RST_EV;
      irq_out <= 1'b0;
    end else begin
      if (wr_ctrl_w) begin
        ctrl_hold_r <= bus_in.wdata[`DSA_CTRL_HOLD];
      end
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_out <= |(status_nxt & mask_nxt);
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0;
    end else begin
      rdata_out <= bus_in.rd ? rd_data_w : 32'h0;
    end
  end

endmodule

/* sim/dsa_sequencer_checker.sv */
// Port-level assertions for the dual-slope sequencer
`timescale 1ns/1ps
module dsa_sequencer_checker import dsa_pkg::*; #(
  parameter int DECADES = 5
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clear_bus_n_in,
  input wire logic comparator_in,
  input wire dsa_bus_t bus_in,
  input wire logic [31:0] rdata_out,
  input wire dsa_switch_t switch_out,
  input wire logic [1:0] state_out,
  input wire logic polarity_out,
  input wire logic latch_pulse_out,
  input wire logic [4*DECADES-1:0] count_out,
  input wire logic blank_out,
  input wire logic data_valid_out,
  input wire logic irq_out
);
  // ----------------------------------------------------------------
  // State span counter
  // ----------------------------------------------------------------
  logic [1:0] prev_r;
  logic [15:0] span_r;
  wire chg = state_out != prev_r;
  // Restart on every change; a held clear bus voids the span
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      prev_r <= 2'h0;
      span_r <= 16'h0;
    end else begin
      prev_r <= state_out;
      span_r <= (chg || !clear_bus_n_in) ? 16'h1 : span_r + 16'h1;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Free-running wrap from the last reference state
  sequence wrap_s;
    state_out == 2'h3 && clear_bus_n_in ##1 state_out == 2'h0;
  endsequence
  az_switch_a:
    assert property (state_out == 2'h0 && !$past(rst_in) |-> switch_out == 6'h38)
    else $error("auto-zero switch pattern wrong");
  sig_switch_a:
    assert property (state_out == 2'h1 |-> switch_out == 6'h04)
    else $error("integrate switch pattern wrong");
  ref_pick_a:
    assert property (state_out[1] |-> switch_out == {4'h0, !polarity_out, polarity_out})
    else $error("reference switch choice wrong");
  pol_hold_a:
    assert property (state_out[1] && $past(state_out[1]) |-> $stable(polarity_out))
    else $error("polarity moved in reference phase");
  state_order_a:
    assert property ($changed(state_out) |->
      state_out == 2'($past(state_out) + 2'h1) || state_out == 2'h0)
    else $error("state order wrong");
  state_span_a:
    assert property (chg && state_out != 2'h1 && clear_bus_n_in |-> span_r == 16'h2710)
    else $error("state span not 10000 cycles");
  hold_az_a:
    assert property (!clear_bus_n_in |=> state_out == 2'h0)
    else $error("clear bus did not hold auto-zero");
  latch_one_a:
    assert property (latch_pulse_out |=> !latch_pulse_out)
    else $error("latch pulse longer than one cycle");
  latch_cause_a:
    assert property (latch_pulse_out |-> $past(state_out[1]))
    else $error("latch pulse outside reference phase");
  valid_wrap_a:
    assert property (wrap_s |-> data_valid_out)
    else $error("no data-valid pulse at wrap");
  blank_az_a:
    assert property (blank_out |-> state_out == 2'h0)
    else $error("blanking outside auto-zero");
endmodule
bind dsa_sequencer dsa_sequencer_checker #(.DECADES(DECADES)) dsa_sequencer_checker_inst (
  .clock_in(clock_in), .rst_in(rst_in), .clear_bus_n_in(clear_bus_n_in),
  .comparator_in(comparator_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .switch_out(switch_out), .state_out(state_out), .polarity_out(polarity_out),
  .latch_pulse_out(latch_pulse_out), .count_out(count_out), .blank_out(blank_out),
  .data_valid_out(data_valid_out), .irq_out(irq_out));

/* sim/dsa_analog_model.sv */
// Behavioural integrator and comparator facing the sequencer switches
`timescale 1ns/1ps
module dsa_analog_model import dsa_pkg::*; (
  input wire logic clock_in,
  input wire dsa_switch_t switch_in,
  input var int vin_in,
  input var int vref_in,
  output logic comparator_out
);
  int integ = 0;
  // Feedback loop nulls the integrator; one step per clock otherwise
  always @(posedge clock_in) begin
    if (switch_in.feedback_switch) integ <= 0;
    else if (switch_in.signal_input_switch) integ <= integ + vin_in;
    else if (switch_in.negative_ref_switch) integ <= integ - vref_in;
    else if (switch_in.positive_ref_switch) integ <= integ + vref_in;
  end
  assign comparator_out = integ > 0;
endmodule

/* sim/test_dual_slope_adc_sequencer.sv */
// Self-checking bench for the dual-slope sequencer
`timescale 1ns/1ps
`include "dsa_map.svh"
module test_dual_slope_adc_sequencer import dsa_pkg::*; ;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic clear_bus_n_in = 1'b0;
  logic comparator_in;
  dsa_bus_t bus_r = '0;
  logic [31:0] rdata_out;
  dsa_switch_t switch_out;
  logic [1:0] state_out;
  logic polarity_out;
  logic latch_pulse_out;
  logic [19:0] count_out;
  logic blank_out;
  logic data_valid_out;
  logic irq_out;
  logic [31:0] rnd;
  int vin = 3;
  int vref = 2;
  int seed = 32'h59E8DD84;
  int n_fail = 0;
  int n_tests = 0;
  dsa_sequencer dsa_sequencer_inst (.clock_in(clock_in), .rst_in(rst_in),
    .clear_bus_n_in(clear_bus_n_in), .comparator_in(comparator_in), .bus_in(bus_r),
    .rdata_out(rdata_out), .switch_out(switch_out), .state_out(state_out),
    .polarity_out(polarity_out), .latch_pulse_out(latch_pulse_out), .count_out(count_out),
    .blank_out(blank_out), .data_valid_out(data_valid_out), .irq_out(irq_out));
  dsa_analog_model dsa_analog_model_inst (.clock_in(clock_in), .switch_in(switch_out),
    .vin_in(vin), .vref_in(vref), .comparator_out(comparator_in));
  initial begin
    forever #25 clock_in = ~clock_in;
  end
  // ----------------------------------------------------------------
  // Reference model and helpers
  // ----------------------------------------------------------------
  // Reading is input over reference times one state span, capped at overload
  function automatic logic [19:0] exp_count(input int v);
    int m;
    logic [19:0] b;
    m = (v < 0 ? -v : v) * 10000 / vref;
    if (m > 19999) m = 19999;
    for (int k = 0; k < 5; k++) begin
      b[4*k +: 4] = 4'(m % 10);
      m = m / 10;
    end
    return b;
  endfunction
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_in);
    bus_r <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_in);
    bus_r.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [4:0] a, input logic [31:0] exp, input string what);
    @(posedge clock_in);
    bus_r <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock_in);
    bus_r.rd <= 1'b0;
    #1;
    chk(rdata_out, exp, what);
  endtask
  // Bounded wait for a one-cycle pulse
  task automatic wait_ev(input bit valid_ev, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clock_in);
      #1;
      if ((valid_ev ? data_valid_out : latch_pulse_out) === 1'b1) return;
    end
    n_fail++;
    $display("Error at %0t: pulse wait ran out", $time);
    print_verdict();
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    cycles(20);
    chk(32'(state_out), 32'h0, "held state");
    chk(32'(switch_out), 32'h38, "auto-zero switches");
    rnd = $random(seed);
    bus_wr(`DSA_OFS_MASK, rnd);
    bus_rd(`DSA_OFS_MASK, rnd & 32'h3, "mask readback");
    bus_rd(5'h14, 32'h0, "unmapped read");
    bus_rd(`DSA_OFS_INFO, 32'h20, "held info");
    bus_wr(`DSA_OFS_MASK, 32'h1);
    clear_bus_n_in <= 1'b1;
    wait_ev(1'b0, 50000);
    chk(32'(count_out), 32'(exp_count(vin)), "positive reading");
    chk(32'(state_out), 32'h3, "crossing state");
    chk(32'(polarity_out), 32'h1, "polarity");
    chk(32'(switch_out), 32'h01, "reference switch");
    wait_ev(1'b1, 30000);
    vin = -5;
    cycles(3);
    chk(32'(irq_out), 32'h1, "done interrupt");
    bus_wr(`DSA_OFS_MASK, 32'h0);
    cycles(2);
    chk(32'(irq_out), 32'h0, "masked interrupt");
    bus_wr(`DSA_OFS_MASK, 32'h1);
    cycles(2);
    chk(32'(irq_out), 32'h1, "unmasked interrupt");
    bus_wr(`DSA_OFS_STATUS, 32'h1);
    cycles(2);
    chk(32'(irq_out), 32'h0, "cleared interrupt");
    wait_ev(1'b1, 50000);
    chk(32'(latch_pulse_out), 32'h1, "overload latch");
    chk(32'(count_out), 32'(exp_count(vin)), "overload reading");
    cycles(3);
    chk(32'(blank_out), 32'h1, "overload blank");
    bus_rd(`DSA_OFS_STATUS, 32'h3, "status after overload");
    print_verdict();
  end
endmodule
